/* File: hw/throttle_speed_command_regs.vh */
`ifndef THROTTLE_SPEED_COMMAND_REGS_VH
`define THROTTLE_SPEED_COMMAND_REGS_VH
// ****************************************
// Register offsets
// ****************************************
`define ADDR_FWD_TOP_M1    4'h0
`define ADDR_FWD_BOTTOM_M1 4'h1
`define ADDR_REV_TOP_M1    4'h2
`define ADDR_REV_BOTTOM_M1 4'h3
`define ADDR_FWD_TOP_M2    4'h4
`define ADDR_FWD_BOTTOM_M2 4'h5
`define ADDR_REV_TOP_M2    4'h6
`define ADDR_REV_BOTTOM_M2 4'h7
`define ADDR_THROTTLE_CFG  4'h8
`define ADDR_VOLT_BOUNDS   4'h9
`define ADDR_SHAPE         4'hA
`define ADDR_STATUS        4'hB
`define ADDR_IRQ_STATUS    4'hC
`define ADDR_IRQ_MASK      4'hD
`define ADDR_SPEED_OUT     4'hE
// ****************************************
// Field positions and values
// ****************************************
`define CFG_TYPE_LSB       0
`define CFG_TYPE_MSB       3
`define CFG_INTERLOCK_BIT  4
`define CFG_LIMITPOT_BIT   5
`define TYPE_MAX           4'h9
`define TYPE_VOLT_FIRST    4'h5
`define PCT_MAX            8'h64
`define VOLT_TOP_MIN       8'h99
`define VOLT_TOP_MAX       8'hFF
`define VOLT_BOTTOM_MAX    8'h66
`define DEADBAND_MIN       8'h05
`define DEADBAND_MAX       8'h1E
`define FULLSCALE_MIN      8'h28
`define FULLSCALE_MAX      8'h64
`define ADC_FULL           8'hFF
`define ADC_MID            8'h80
`define IRQ_REJECT_BIT     0
`define IRQ_FAULT_BIT      1
`define IRQ_MODE_BIT       2
`define RESET_TOP          8'h64
`define RESET_BOTTOM       8'h00
`define RESET_CFG          8'h10
`define RESET_VTOP         8'hFF
`define RESET_VBOTTOM      8'h00
`define RESET_DEADBAND     8'h0A
`define RESET_FULLSCALE    8'h5A
// ****************************************
// Timing
// ****************************************
`define CLK_MHZ            200
`define INTERLOCK_SECONDS  10
`define DEBOUNCE_US        10000
`endif

/* File: hw/mode_debounce.v */
`include "throttle_speed_command_regs.vh"
module mode_debounce #(
  parameter DEBOUNCE_CYCLES = `DEBOUNCE_US * `CLK_MHZ
) (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire rawIn,
  output reg  cleanOut
);
  reg        sync1_reg;
  reg        sync2_reg;
  reg [31:0] count_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      count_reg <= 32'h0;
      cleanOut  <= 1'b0;
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      if (sync2_reg == cleanOut) begin
        count_reg <= 32'h0;
      end else if (count_reg >= DEBOUNCE_CYCLES - 1) begin
        count_reg <= 32'h0;
        cleanOut  <= sync2_reg;
      end else begin
        count_reg <= count_reg + 32'h1;
      end
    end
  end
endmodule

/* File: hw/throttle_speed_command.v */
`include "throttle_speed_command_regs.vh"
module throttle_speed_command #(
  parameter INTERLOCK_CYCLES = `INTERLOCK_SECONDS * `CLK_MHZ * 1000000,
  parameter DEBOUNCE_CYCLES  = `DEBOUNCE_US * `CLK_MHZ
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata,
  input  wire       modeSwitch,
  input  wire [7:0] throttleAdc,
  input  wire [7:0] limitPotAdc,
  output reg  [7:0] speedCommand,
  output reg        reverseDir,
  output reg        driveInhibit,
  output reg        wiringFault,
  output wire       irq
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] limit_reg [0:7];
  reg  [7:0] cfg_reg;
  reg  [7:0] vTop_reg;
  reg  [7:0] vBottom_reg;
  reg  [7:0] deadband_reg;
  reg  [7:0] fullScale_reg;
  reg  [2:0] irqStatus_reg;
  reg  [2:0] irqMask_reg;
  reg        modeTwo_reg;
  reg        modePrev_reg;
  reg        rejectEvt;
  wire       modeClean;
  wire [3:0] throttleType = cfg_reg[`CFG_TYPE_MSB:`CFG_TYPE_LSB];
  wire       interlockOn  = cfg_reg[`CFG_INTERLOCK_BIT];
  wire       limitPotOn   = cfg_reg[`CFG_LIMITPOT_BIT];
  // ****************************************
  // Mode selection
  // ****************************************
  // The raw switch is filtered so that contact bounce never flips the mode.
  // debounced mode
  mode_debounce #(
    .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
  ) u_mode (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .rawIn    (modeSwitch),
    .cleanOut (modeClean)
  );
  // The mode bit is registered once more so that a change shows as an event.
  // mode selection
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeTwo_reg  <= 1'b0;
      modePrev_reg <= 1'b0;
    end else begin
      modeTwo_reg  <= modeClean;
      modePrev_reg <= modeTwo_reg;
    end
  end
  // ****************************************
  // Register writes
  // ****************************************
  wire [2:0] wIdx     = regAddr[2:0];
  wire       isBottom = regAddr[0];
  wire [7:0] pairTop  = limit_reg[{wIdx[2:1], 1'b0}];
  wire [7:0] pairBot  = limit_reg[{wIdx[2:1], 1'b1}];
  reg        limitOk;
  // A top write below its bottom is refused as well, so each pair stays ordered.
  always @* begin
    limitOk = regWdata <= `PCT_MAX;
    if (isBottom && regWdata > pairTop) begin
      limitOk = 1'b0;
    end
    if (!isBottom && regWdata < pairBot) begin
      limitOk = 1'b0;
    end
  end
  // ****************************************
  // Limit storage
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : gLimit
      // Each limit slot loads only when its pair check passes.
      // per-mode direction limits
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          limit_reg[gi] <= (gi % 2 == 1) ? `RESET_BOTTOM : `RESET_TOP;
        end else if (regWrite && !regAddr[3] && wIdx == gi && limitOk) begin
          limit_reg[gi] <= regWdata;
        end
      end
    end
  endgenerate
  // ****************************************
  // Configuration writes
  // ****************************************
  // The voltage bound address holds two fields; the written value picks which one.
  // A refused write raises a one-cycle reject event.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg       <= `RESET_CFG;
      vTop_reg      <= `RESET_VTOP;
      vBottom_reg   <= `RESET_VBOTTOM;
      deadband_reg  <= `RESET_DEADBAND;
      fullScale_reg <= `RESET_FULLSCALE;
      irqMask_reg   <= 3'h0;
      rejectEvt     <= 1'b0;
    end else begin
      rejectEvt <= 1'b0;
      if (regWrite) begin
        case (regAddr)
          `ADDR_THROTTLE_CFG: begin
            if (regWdata[`CFG_TYPE_MSB:`CFG_TYPE_LSB] <= `TYPE_MAX) begin
              cfg_reg <= {2'h0, regWdata[5:0]};
            end else begin
              rejectEvt <= 1'b1;
            end
          end
          `ADDR_VOLT_BOUNDS: begin
            if (regWdata >= `VOLT_TOP_MIN) begin
              vTop_reg <= regWdata;
            end else if (regWdata <= `VOLT_BOTTOM_MAX) begin
              vBottom_reg <= regWdata;
            end else begin
              rejectEvt <= 1'b1;
            end
          end
          `ADDR_SHAPE: begin
            if (regWdata >= `DEADBAND_MIN && regWdata <= `DEADBAND_MAX) begin
              deadband_reg <= regWdata;
            end else if (regWdata >= `FULLSCALE_MIN && regWdata <= `FULLSCALE_MAX) begin
              fullScale_reg <= regWdata;
            end else begin
              rejectEvt <= 1'b1;
            end
          end
          `ADDR_IRQ_MASK: begin
            irqMask_reg <= regWdata[2:0];
          end
          default: begin
            if (!regAddr[3] && !limitOk) begin
              rejectEvt <= 1'b1;
            end
          end
        endcase
      end
    end
  end
  // ****************************************
  // Throttle decode
  // ****************************************
  wire       voltType = throttleType >= `TYPE_VOLT_FIRST;
  wire [3:0] shape    = voltType ? throttleType - `TYPE_VOLT_FIRST : throttleType;
  wire [7:0] lowB     = voltType ? vBottom_reg : 8'h00;
  wire [7:0] highB    = voltType ? vTop_reg : `ADC_FULL;
  // The wiper is clamped to the active bounds before it is scaled.
  wire [7:0] clipped  = throttleAdc < lowB ? lowB : (throttleAdc > highB ? highB : throttleAdc);
  wire [7:0] span     = highB - lowB;
  wire [15:0] posMul  = (clipped - lowB) * `PCT_MAX;
  // A zero span would divide by zero, so it reads as position zero.
  wire [15:0] posQuot = span == 8'h00 ? 16'h0000 : posMul / span;
  wire [7:0] posPct   = posQuot[7:0];
  // ****************************************
  // Throttle shape
  // ****************************************
  // Wigwag shapes are neutral at mid travel and the half sets direction; unipolar shapes are neutral at one end.
  reg  [7:0] magPct;
  reg        revRaw;
  always @* begin
    magPct = 8'h00;
    revRaw = 1'b0;
    case (shape)
      4'h0, 4'h4: begin
        revRaw = posPct < 8'h32;
        magPct = revRaw ? (8'h32 - posPct) << 1 : (posPct - 8'h32) << 1;
      end
      4'h1: begin
        revRaw = posPct >= 8'h32;
        magPct = revRaw ? (posPct - 8'h32) << 1 : (8'h32 - posPct) << 1;
      end
      4'h2: begin
        magPct = posPct;
      end
      4'h3: begin
        magPct = `PCT_MAX - posPct;
      end
      default: begin
        magPct = 8'h00;
      end
    endcase
    if (magPct > `PCT_MAX) begin
      magPct = `PCT_MAX;
    end
  end
  // ****************************************
  // Deadband and full scale
  // ****************************************
  // Positions at or below the deadband read as neutral.
  // neutral deadband
  wire        inNeutral = magPct <= deadband_reg;
  // Travel past the full-scale point saturates at full output.
  // full-scale scaling
  wire [7:0]  active    = inNeutral ? 8'h00 : magPct - deadband_reg;
  wire [7:0]  range     = fullScale_reg - deadband_reg;
  wire [15:0] cmdMul    = active * `PCT_MAX;
  wire [15:0] cmdQuot   = range == 8'h00 ? 16'h0000 : cmdMul / range;
  wire [7:0]  cmdRaw    = (range == 8'h00 || active >= range) ? `PCT_MAX : cmdQuot[7:0];
  // ****************************************
  // Speed limit
  // ****************************************
  wire [2:0]  base     = {modeTwo_reg, revRaw, 1'b0};
  wire [7:0]  topLim   = limit_reg[base];
  // With the pot disabled both ends of the sweep sit at the top limit.
  // bottom only with pot on
  wire [7:0]  botLim   = limitPotOn ? limit_reg[base | 3'h1] : topLim;
  // The pot sweeps the limit from bottom at code zero to top at full code.
  // linear interpolation
  wire [15:0] interp   = botLim * `ADC_FULL + (topLim - botLim) * limitPotAdc;
  wire [15:0] effQuot  = interp / `ADC_FULL;
  wire [7:0]  effLim   = effQuot[7:0];
  wire [15:0] outMul   = cmdRaw * effLim;
  wire [15:0] speedQuot = outMul / `PCT_MAX;
  wire [7:0]  speedNext = speedQuot[7:0];
  // ****************************************
  // Power-up interlock
  // ****************************************
  // The interlock arms only out of reset; a fault inhibits until the next reset.
  reg         armed_reg;
  reg  [31:0] ilCount_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg    <= 1'b1;
      driveInhibit <= 1'b1;
      wiringFault  <= 1'b0;
      ilCount_reg  <= 32'h0;
      speedCommand <= 8'h00;
      reverseDir   <= 1'b0;
    end else begin
      if (armed_reg) begin
        if (!interlockOn || inNeutral) begin
          armed_reg    <= 1'b0;
          driveInhibit <= 1'b0;
        end else if (ilCount_reg >= INTERLOCK_CYCLES - 1) begin
          wiringFault <= 1'b1;
        end else begin
          ilCount_reg <= ilCount_reg + 32'h1;
        end
      end
      if (wiringFault) begin
        armed_reg    <= 1'b0;
        driveInhibit <= 1'b1;
      end
      speedCommand <= (driveInhibit || wiringFault) ? 8'h00 : speedNext;
      reverseDir   <= revRaw & ~inNeutral;
    end
  end
  // ****************************************
  // Interrupt status and output
  // ****************************************
  // An event in the same cycle as its clear wins, so no event is lost.
  wire [2:0] irqSet = {modeTwo_reg ^ modePrev_reg, wiringFault, rejectEvt};
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_reg <= 3'h0;
    end else begin
      irqStatus_reg <= irqSet | (irqStatus_reg &
        ~((regWrite && regAddr == `ADDR_IRQ_STATUS) ? regWdata[2:0] : 3'h0));
    end
  end
  assign irq = |(irqStatus_reg & irqMask_reg);
  // ****************************************
  // Register readback
  // ****************************************
  // Read data stand for one cycle and are zero otherwise.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_THROTTLE_CFG: begin
          regRdata <= cfg_reg;
        end
        `ADDR_VOLT_BOUNDS: begin
          regRdata <= vTop_reg;
        end
        `ADDR_SHAPE: begin
          regRdata <= deadband_reg;
        end
        `ADDR_STATUS: begin
          regRdata <= {3'h0, inNeutral, revRaw, modeTwo_reg, wiringFault, driveInhibit};
        end
        `ADDR_IRQ_STATUS: begin
          regRdata <= {5'h0, irqStatus_reg};
        end
        `ADDR_IRQ_MASK: begin
          regRdata <= {5'h0, irqMask_reg};
        end
        `ADDR_SPEED_OUT: begin
          regRdata <= speedCommand;
        end
        4'hF: begin
          regRdata <= fullScale_reg;
        end
        default: begin
          regRdata <= limit_reg[wIdx];
        end
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule

/* File: testbench/throttle_speed_command_assertions.sv */
module throttle_speed_command_checker #(
  parameter INTERLOCK_CYCLES = 100,
  parameter DEBOUNCE_CYCLES  = 4
) (
  input wire       clk_sys,
  input wire       rst_n,
  input wire [3:0] regAddr,
  input wire [7:0] regWdata,
  input wire       regWrite,
  input wire       regRead,
  input wire [7:0] regRdata,
  input wire       modeSwitch,
  input wire [7:0] throttleAdc,
  input wire [7:0] limitPotAdc,
  input wire [7:0] speedCommand,
  input wire       reverseDir,
  input wire       driveInhibit,
  input wire       wiringFault,
  input wire       irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence rejectWr;
    regWrite && regAddr == 4'h0 && regWdata > 8'h64;
  endsequence
  sequence statusRd;
    regRead && regAddr == 4'hC;
  endsequence
  sequence inhibitHeld;
    driveInhibit ##1 driveInhibit;
  endsequence
  AST_RDATA_IDLE: assert property (!regRead |=> regRdata == 8'h00)
    else $error("read data not zero when idle");
  AST_SPEED_RANGE: assert property (speedCommand <= 8'h64)
    else $error("speed above full scale");
  AST_SPEED_READ: assert property (regRead && regAddr == 4'hE |=> regRdata == $past(speedCommand))
    else $error("speed readback differs");
  AST_REJECT_FLAG: assert property (rejectWr ##[2:4] statusRd |=> regRdata[0])
    else $error("rejected write not flagged");
  AST_MASK_OFF: assert property (regWrite && regAddr == 4'hD && regWdata == 8'h00 |=> !irq)
    else $error("irq high with all masked");
  AST_FAULT_STICKY: assert property (wiringFault |=> wiringFault)
    else $error("wiring fault cleared");
  AST_FAULT_INHIBIT: assert property ($rose(wiringFault) |-> driveInhibit)
    else $error("fault without inhibit");
  AST_INHIBIT_IDLE: assert property (inhibitHeld |-> speedCommand == 8'h00)
    else $error("speed while inhibited");
endmodule

bind throttle_speed_command throttle_speed_command_checker #(
  .INTERLOCK_CYCLES(INTERLOCK_CYCLES),
  .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
) checkerInst (
  .clk_sys     (clk_sys),
  .rst_n       (rst_n),
  .regAddr     (regAddr),
  .regWdata    (regWdata),
  .regWrite    (regWrite),
  .regRead     (regRead),
  .regRdata    (regRdata),
  .modeSwitch  (modeSwitch),
  .throttleAdc (throttleAdc),
  .limitPotAdc (limitPotAdc),
  .speedCommand(speedCommand),
  .reverseDir  (reverseDir),
  .driveInhibit(driveInhibit),
  .wiringFault (wiringFault),
  .irq         (irq)
);

/* File: testbench/throttle_partner.sv */
module throttle_partner (
  input  wire        clk_sys,
  input  wire  [7:0] wiperSet,
  input  wire  [7:0] potSet,
  input  wire        modeSet,
  output logic [7:0] throttleAdc,
  output logic [7:0] limitPotAdc,
  output logic       modeSwitch
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] bounce;
  initial begin
    throttleAdc = 8'h80;
    limitPotAdc = 8'hFF;
    modeSwitch  = 1'b0;
    bounce      = 2'd0;
  end
  always @(posedge clk_sys) begin
    throttleAdc <= wiperSet;
    limitPotAdc <= potSet;
    if (bounce != 2'd0) begin
      bounce     <= bounce - 2'd1;
      modeSwitch <= (bounce == 2'd1) ? modeSet : ~modeSwitch;
    end else if (modeSet != modeSwitch) begin
      bounce     <= 2'd3;
      modeSwitch <= modeSet;
    end
  end
endmodule

/* File: testbench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ILK = 100;
  logic        clk_sys, rst_n, regWrite, regRead, modeSet, irq;
  logic        modeSwitch, reverseDir, driveInhibit, wiringFault;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, wiperSet, potSet, throttleAdc, limitPotAdc, speedCommand;
  logic [7:0]  lim [8];
  logic [7:0]  topV [4] = '{8'h50, 8'h3C, 8'h46, 8'h32};
  logic [7:0]  botV [4] = '{8'h20, 8'h10, 8'h14, 8'h0A};
  logic [3:0]  badA [7] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hA, 4'hA, 4'hA};
  logic [7:0]  badD [7] = '{8'h65, 8'h0A, 8'h80, 8'h04, 8'h1F, 8'h27, 8'h65};
  logic [47:0] rows [14] = '{48'h20FFFF005000, 48'h20FF00002000, 48'h2000FF003C01, 48'h200000001001,
    48'h2084FF000000, 48'h00FF00005000, 48'h01FFFF003C01, 48'h05FFFF005000, 48'h20FFFF014600,
    48'h200000010A01, 48'h20FF80003800, 48'h22FFFF005000, 48'h2300FF005000, 48'h2400FF003C01};
  logic [47:0] r;
  logic [31:0] seed = 32'd55198;
  int          fails = 0;
  int          n_compared = 0;
  int          a, d;
  throttle_speed_command #(.INTERLOCK_CYCLES(ILK), .DEBOUNCE_CYCLES(4)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .modeSwitch(modeSwitch), .throttleAdc(throttleAdc),
    .limitPotAdc(limitPotAdc), .speedCommand(speedCommand), .reverseDir(reverseDir),
    .driveInhibit(driveInhibit), .wiringFault(wiringFault), .irq(irq)
  );
  throttle_partner partner (
    .clk_sys(clk_sys), .wiperSet(wiperSet), .potSet(potSet), .modeSet(modeSet),
    .throttleAdc(throttleAdc), .limitPotAdc(limitPotAdc), .modeSwitch(modeSwitch)
  );
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // A limit write is kept only inside 0..100 with bottom not above top.
  function automatic bit accepted(int ad, int dv);
    return dv <= 100 && ((ad % 2) ? dv <= lim[ad - 1] : dv >= lim[ad + 1]);
  endfunction
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] dv);
    @(posedge clk_sys);
    regAddr  <= ad;
    regWdata <= dv;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [7:0] exp);
    @(posedge clk_sys);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  // Selector: 0 speed, 1 fault, 2 inhibit.
  task automatic waitOn(input int sel, input logic [7:0] exp, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if ((sel == 0 ? speedCommand : {7'h00, sel == 1 ? wiringFault : driveInhibit}) === exp) return;
    end
    fails++;
    $display("MISMATCH %0t wait ran out", $time);
    results();
  endtask
  task automatic doRst(input logic [7:0] w);
    @(posedge clk_sys);
    wiperSet <= w;
    rst_n    <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  initial begin
    rst_n    = 1'b0;
    regWrite = 1'b0;
    regRead  = 1'b0;
    regAddr  = 4'h0;
    regWdata = 8'h00;
    wiperSet = 8'h80;
    potSet   = 8'hFF;
    modeSet  = 1'b0;
    doRst(8'hFF);
    @(posedge clk_sys);
    #1 chk({7'h00, driveInhibit}, 8'h01);
    repeat (ILK / 2) @(posedge clk_sys);
    #1 chk({7'h00, wiringFault}, 8'h00);
    waitOn(1, 8'h01, 3 * ILK);
    @(posedge clk_sys);
    wiperSet <= 8'h80;
    repeat (20) @(posedge clk_sys);
    #1 chk({7'h00, wiringFault}, 8'h01);
    wr(4'hD, 8'h02);
    #1 chk({7'h00, irq}, 8'h01);
    doRst(8'hFF);
    repeat (ILK / 4) @(posedge clk_sys);
    wiperSet <= 8'h80;
    waitOn(2, 8'h00, 50);
    repeat (2 * ILK) @(posedge clk_sys);
    #1 chk({7'h00, wiringFault}, 8'h00);
    $display("interlock tests done");
    for (int i = 0; i < 8; i++) begin
      lim[i] = i[0] ? 8'h00 : 8'h64;
      rd(i[3:0], lim[i]);
    end
    rd(4'h8, 8'h10);
    rd(4'h9, 8'hFF);
    rd(4'hA, 8'h0A);
    rd(4'hF, 8'h5A);
    for (int i = 0; i < 24; i++) begin
      a = int'(rnd() % 8);
      d = int'(rnd() % 128);
      wr(a[3:0], d[7:0]);
      if (accepted(a, d)) lim[a] = d[7:0];
      rd(a[3:0], lim[a]);
    end
    wr(4'hC, 8'h07);
    wr(4'hD, 8'h01);
    foreach (badA[i]) begin
      wr(badA[i], badD[i]);
      rd(4'hC, 8'h01);
      chk({7'h00, irq}, 8'h01);
      wr(4'hC, 8'h07);
      #1 chk({7'h00, irq}, 8'h00);
    end
    wr(4'hD, 8'h00);
    #1 chk({7'h00, irq}, 8'h00);
    rd(4'hA, 8'h0A);
    $display("register tests done");
    for (int k = 0; k < 4; k++) begin
      wr(4'(2 * k + 1), 8'h00);
      wr(4'(2 * k), topV[k]);
      wr(4'(2 * k + 1), botV[k]);
    end
    foreach (rows[i]) begin
      r = rows[i];
      wr(4'h8, r[47:40]);
      @(posedge clk_sys);
      wiperSet <= r[39:32];
      potSet   <= r[31:24];
      modeSet  <= r[16];
      waitOn(0, r[15:8], 60);
      @(posedge clk_sys);
      #1 chk({7'h00, reverseDir}, r[7:0]);
      rd(4'hE, r[15:8]);
    end
    $display("speed tests done");
    results();
  end
endmodule
